// file: src/iodec_cc_filter.v
`timescale 1ns/1ps
`include "iodec_regs.vh"
// Folds any pattern a channel returns onto the assigned condition codes
module iodec_cc_filter (
    // Raw code
    input  wire [3:0] cc_raw_i,
    // Legal code
    output reg  [3:0] cc_o
);
    always @* begin
        case (cc_raw_i)
            `IODEC_CC_ACTIVATED,
            `IODEC_CC_CHAN_BUSY,
            `IODEC_CC_INOPERABLE,
            `IODEC_CC_SUB_BUSY,
            `IODEC_CC_STORED,
            `IODEC_CC_UNSUPPORTED,
            `IODEC_CC_QUEUED: begin
                cc_o = cc_raw_i;
            end
            // An unassigned pattern is reported as unsupported
            default: begin
                cc_o = `IODEC_CC_UNSUPPORTED;
            end
        endcase
    end
endmodule

// file: src/iodec_regs.vh
`ifndef IODEC_REGS_VH
`define IODEC_REGS_VH
// Register offsets (plain port, word index)
`define IODEC_REG_CTRL        4'h0
`define IODEC_REG_STATUS      4'h1
`define IODEC_REG_LCSA        4'h2
`define IODEC_REG_FUNC        4'h3
// Control fields
`define IODEC_CTRL_DWMODE     0
`define IODEC_CTRL_CTRL_RST   32'h0000_0000
// Status fields
`define IODEC_ST_CC_LSB       0
`define IODEC_ST_SENSE        4
`define IODEC_ST_WCS_ARM      7
// Instruction fields (bit 0 is the msb of the word)
`define IODEC_OPC_CLASSF      6'h3f
`define IODEC_AUG_CLASSF      3'h7
// Sub-operation codes
`define IODEC_SOP_START       4'h2
`define IODEC_SOP_TEST        4'h3
`define IODEC_SOP_HALT_DESC   4'h4
`define IODEC_SOP_CHAN_RST    4'h5
`define IODEC_SOP_TERM        4'h6
`define IODEC_SOP_SEIZE       4'h7
`define IODEC_SOP_CTL_RST     4'h8
`define IODEC_SOP_CS_LOAD_EN  4'h9
`define IODEC_SOP_CS_WRITE    4'hb
`define IODEC_SOP_IRQ_EN      4'hc
`define IODEC_SOP_IRQ_DIS     4'hd
`define IODEC_SOP_IRQ_ACT     4'he
`define IODEC_SOP_IRQ_DEACT   4'hf
// Condition codes, first bit most significant
`define IODEC_CC_ACTIVATED    4'h0
`define IODEC_CC_CHAN_BUSY    4'h1
`define IODEC_CC_INOPERABLE   4'h2
`define IODEC_CC_SUB_BUSY     4'h3
`define IODEC_CC_STORED       4'h4
`define IODEC_CC_UNSUPPORTED  4'h5
`define IODEC_CC_QUEUED       4'h8
// Legacy test codes
`define IODEC_TD_CHAN_ERR     16'h8000
`define IODEC_TD_PROG_VIOL    16'h4000
`define IODEC_TD_STATUS       16'h2000
`define IODEC_TD_CC3          4'h2
`define IODEC_TD_CC2          4'h4
// Channel answer timeout in cycles
`define IODEC_ANS_TIMEOUT     8'hff
`endif

// file: src/iodec_top.v
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "iodec_regs.vh"
module iodec_top #(
    parameter TMO_W = 8
) (
    // Clock and reset
    input  wire        clk_sys_i,
    input  wire        sys_rst_i,
    // Instruction issue
    input  wire        instr_valid_i,
    input  wire [31:0] instr_i,
    input  wire        is_legacy_i,
    input  wire        is_sense_en_i,
    input  wire        is_sense_dis_i,
    input  wire [31:0] gpr_data_i,
    input  wire        dw_mode_i,
    output wire [2:0]  gpr_sel_o,
    output reg         done_o,
    output reg  [3:0]  cc_o,
    output reg         cc_we_o,
    output reg         trap_syschk_o,
    output reg         trap_undef_o,
    output reg         irq_sense_o,
    // Channel class lookup
    output wire [6:0]  class_query_o,
    input  wire        chan_classf_i,
    input  wire        chan_present_i,
    input  wire        chan_busy_i,
    // Channel-class request
    output reg         chan_req_o,
    output reg  [3:0]  chan_op_o,
    output reg  [31:0] chan_addr_o,
    input  wire        chan_ack_i,
    input  wire [3:0]  chan_cc_i,
    // Legacy device request
    output reg         dev_req_o,
    output reg  [6:0]  dev_num_o,
    output reg  [15:0] dev_func_o,
    output reg         dev_is_test_o,
    input  wire        dev_ack_i,
    input  wire [3:0]  dev_cc_i,
    // Register port
    input  wire [3:0]  reg_addr_i,
    input  wire [31:0] reg_wdata_i,
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    output reg  [31:0] reg_rdata_o
);
    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    localparam [3:0] S_IDLE = 4'b0001;
    localparam [3:0] S_CHAN = 4'b0010;
    localparam [3:0] S_DEV  = 4'b0100;
    localparam [3:0] S_DONE = 4'b1000;

    reg  [3:0]       state_reg;
    reg  [3:0]       state_next;
    reg  [31:0]      ctrl_reg;
    reg  [31:0]      lcsa_reg;
    reg  [15:0]      func_reg;
    reg  [3:0]       cc_last_reg;
    reg              wcs_arm_reg;
    reg  [TMO_W-1:0] tmo_reg;
    wire [3:0]       chan_cc_legal;

    // ------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------
    // Bit n of the word is instr_i[31-n]
    wire [5:0]  f_opc    = instr_i[31:26];
    wire [6:0]  f_dev    = instr_i[25:19];
    wire [2:0]  f_aug    = instr_i[18:16];
    wire [15:0] f_func   = instr_i[15:0];
    wire [2:0]  f_reg    = instr_i[25:23];
    wire [3:0]  f_sop    = instr_i[22:19];
    wire        f_test   = instr_i[16];
    wire        is_classf = (f_opc == `IODEC_OPC_CLASSF) && (f_aug == `IODEC_AUG_CLASSF);

    assign gpr_sel_o     = f_reg;

    // Logical channel and subaddress
    function [31:0] form_lcsa;
        input [2:0]  rsel;
        input [31:0] rval;
        input [15:0] cnst;
        begin
            if (rsel != 3'h0) begin
                form_lcsa = rval + {16'h0000, cnst};
            end else begin
                form_lcsa = {16'h0000, cnst};
            end
        end
    endfunction

    // Channel-class lookup follows the register offset; otherwise the device field is used
    wire [31:0] lcsa_now = form_lcsa(f_reg, gpr_data_i, f_func);
    assign class_query_o = is_classf ? lcsa_now[15:9] : f_dev;

    // Sub-op validity
    function sop_assigned;
        input [3:0] sop;
        begin
            case (sop)
                `IODEC_SOP_START, `IODEC_SOP_TEST, `IODEC_SOP_HALT_DESC,
                `IODEC_SOP_CHAN_RST, `IODEC_SOP_TERM, `IODEC_SOP_SEIZE,
                `IODEC_SOP_CTL_RST, `IODEC_SOP_CS_LOAD_EN, `IODEC_SOP_CS_WRITE,
                `IODEC_SOP_IRQ_EN, `IODEC_SOP_IRQ_DIS, `IODEC_SOP_IRQ_ACT,
                `IODEC_SOP_IRQ_DEACT: begin
                    sop_assigned = 1'b1;
                end
                default: begin
                    sop_assigned = 1'b0;
                end
            endcase
        end
    endfunction

    // Word-mode test toward a channel-class channel
    function [3:0] td_word_cc;
        input [15:0] code;
        begin
            if (code == `IODEC_TD_CHAN_ERR || code == `IODEC_TD_PROG_VIOL) begin
                td_word_cc = `IODEC_TD_CC3;
            end else if (code == `IODEC_TD_STATUS) begin
                td_word_cc = `IODEC_TD_CC2;
            end else begin
                td_word_cc = 4'h0;
            end
        end
    endfunction

    // Mode comes from the pin or from software control
    wire dw_mode = dw_mode_i | ctrl_reg[`IODEC_CTRL_DWMODE];

    iodec_cc_filter u_cc_filter (
        .cc_raw_i (chan_cc_i),
        .cc_o     (chan_cc_legal)
    );

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always @* begin
        state_next = state_reg;
        case (state_reg)
            S_IDLE: begin
                if (instr_valid_i) begin
                    state_next = S_DONE;
                end
            end
            S_CHAN: begin
                if (chan_ack_i || tmo_reg == `IODEC_ANS_TIMEOUT) begin
                    state_next = S_DONE;
                end
            end
            S_DEV: begin
                if (dev_ack_i || tmo_reg == `IODEC_ANS_TIMEOUT) begin
                    state_next = S_DONE;
                end
            end
            S_DONE: begin
                state_next = S_IDLE;
            end
            default: begin
                state_next = S_IDLE;
            end
        endcase
    end

    always @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg     <= S_IDLE;
            done_o        <= 1'b0;
            cc_o          <= 4'h0;
            cc_we_o       <= 1'b0;
            trap_syschk_o <= 1'b0;
            trap_undef_o  <= 1'b0;
            irq_sense_o   <= 1'b0;
            chan_req_o    <= 1'b0;
            chan_op_o     <= 4'h0;
            chan_addr_o   <= 32'h0000_0000;
            dev_req_o     <= 1'b0;
            dev_num_o     <= 7'h00;
            dev_func_o    <= 16'h0000;
            dev_is_test_o <= 1'b0;
            lcsa_reg      <= 32'h0000_0000;
            func_reg      <= 16'h0000;
            cc_last_reg   <= 4'h0;
            wcs_arm_reg   <= 1'b0;
            tmo_reg       <= {TMO_W{1'b0}};
        end else begin
            done_o        <= 1'b0;
            cc_we_o       <= 1'b0;
            trap_syschk_o <= 1'b0;
            trap_undef_o  <= 1'b0;
            state_reg     <= state_next;
            case (state_reg)
                S_IDLE: begin
                    tmo_reg <= {TMO_W{1'b0}};
                    if (instr_valid_i) begin
                        if (is_sense_en_i) begin
                            irq_sense_o <= 1'b1;
                        end else if (is_sense_dis_i) begin
                            irq_sense_o <= 1'b0;
                        end else if (is_classf) begin
                            lcsa_reg <= lcsa_now;
                            if (!chan_present_i) begin
                                cc_o    <= `IODEC_CC_INOPERABLE;
                                cc_we_o <= 1'b1;
                            end else if (!chan_classf_i) begin
                                trap_undef_o <= 1'b1;
                            end else if (!sop_assigned(f_sop)) begin
                                cc_o    <= `IODEC_CC_UNSUPPORTED;
                                cc_we_o <= 1'b1;
                            end else if (chan_busy_i) begin
                                cc_o    <= `IODEC_CC_CHAN_BUSY;
                                cc_we_o <= 1'b1;
                            end else begin
                                // Write without a preceding load enable is refused
                                if (f_sop == `IODEC_SOP_CS_WRITE && !wcs_arm_reg) begin
                                    cc_o    <= `IODEC_CC_UNSUPPORTED;
                                    cc_we_o <= 1'b1;
                                end else begin
                                    // Start, halt and all others go to the channel
                                    chan_req_o  <= 1'b1;
                                    chan_op_o   <= f_sop;
                                    chan_addr_o <= lcsa_now;
                                    state_reg   <= S_CHAN;
                                end
                                wcs_arm_reg <= (f_sop == `IODEC_SOP_CS_LOAD_EN);
                            end
                        end else if (is_legacy_i) begin
                            func_reg <= f_func;
                            if (chan_classf_i) begin
                                if (dw_mode) begin
                                    trap_syschk_o <= 1'b1;
                                end else if (f_test) begin
                                    cc_o    <= td_word_cc(f_func);
                                    cc_we_o <= 1'b1;
                                end
                            end else begin
                                dev_req_o     <= 1'b1;
                                dev_num_o     <= f_dev;
                                dev_is_test_o <= f_test;
                                // Test carries only bits 16-27
                                dev_func_o    <= f_test ? {f_func[15:4], 4'h0} : f_func;
                                state_reg     <= S_DEV;
                            end
                        end
                    end
                end
                S_CHAN: begin
                    chan_req_o <= 1'b0;
                    tmo_reg    <= tmo_reg + 1'b1;
                    if (chan_ack_i) begin
                        cc_o    <= chan_cc_legal;
                        cc_we_o <= 1'b1;
                    end else if (tmo_reg == `IODEC_ANS_TIMEOUT) begin
                        // A silent channel counts as inoperable
                        cc_o    <= `IODEC_CC_INOPERABLE;
                        cc_we_o <= 1'b1;
                    end
                end
                S_DEV: begin
                    dev_req_o <= 1'b0;
                    tmo_reg   <= tmo_reg + 1'b1;
                    if (dev_ack_i && dev_is_test_o) begin
                        cc_o    <= dev_cc_i;
                        cc_we_o <= 1'b1;
                    end
                end
                S_DONE: begin
                    done_o <= 1'b1;
                    if (cc_we_o) begin
                        cc_last_reg <= cc_o;
                    end
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    always @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl_reg    <= `IODEC_CTRL_CTRL_RST;
            reg_rdata_o <= 32'h0000_0000;
        end else begin
            if (reg_wr_i && reg_addr_i == `IODEC_REG_CTRL) begin
                ctrl_reg <= {31'h0000_0000, reg_wdata_i[`IODEC_CTRL_DWMODE]};
            end
            reg_rdata_o <= 32'h0000_0000;
            if (reg_rd_i) begin
                case (reg_addr_i)
                    `IODEC_REG_CTRL: begin
                        reg_rdata_o <= ctrl_reg;
                    end
                    `IODEC_REG_STATUS: begin
                        reg_rdata_o <= {24'h000000, wcs_arm_reg, 2'b00, irq_sense_o, cc_last_reg};
                    end
                    `IODEC_REG_LCSA: begin
                        reg_rdata_o <= lcsa_reg;
                    end
                    `IODEC_REG_FUNC: begin
                        reg_rdata_o <= {16'h0000, func_reg};
                    end
                    default: begin
                        reg_rdata_o <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end
endmodule

// file: tb/io_instruction_decode_tb.sv
`timescale 1ns/1ps
module io_instruction_decode_tb;
    reg         clk_sys_i = 1'b0;
    reg         sys_rst_i = 1'b1;
    reg         instr_valid_i = 1'b0;
    reg  [31:0] instr_i = 32'h0;
    reg         is_legacy_i = 1'b0, is_sense_en_i = 1'b0, is_sense_dis_i = 1'b0;
    reg  [31:0] gpr_data_i = 32'h0;
    reg         dw_mode_i = 1'b0, chan_classf_i = 1'b0, chan_present_i = 1'b0, chan_busy_i = 1'b0;
    reg  [3:0]  reg_addr_i = 4'h0;
    reg  [31:0] reg_wdata_i = 32'h0;
    reg         reg_wr_i = 1'b0, reg_rd_i = 1'b0, m_mute = 1'b0;
    reg  [7:0]  m_dly = 8'h0;
    reg  [3:0]  m_cc = 4'h0;
    wire        done_o, cc_we_o, trap_syschk_o, trap_undef_o, irq_sense_o, chan_req_o, chan_ack_i;
    wire        dev_req_o, dev_is_test_o, dev_ack_i;
    wire [3:0]  cc_o, chan_op_o, chan_cc_i, dev_cc_i;
    wire [31:0] chan_addr_o, reg_rdata_o;
    wire [6:0]  dev_num_o, class_query_o;
    wire [2:0]  gpr_sel_o;
    wire [15:0] dev_func_o;
    integer     err_total = 0, comparisons = 0, s;
    reg         sw, sy, su, sq, sd, dt;
    reg  [9:0]  lk;
    reg  [3:0]  sc, qop;
    reg  [31:0] qad, rd;
    reg  [6:0]  dnum;
    reg  [15:0] dfn;
    always #2 clk_sys_i = ~clk_sys_i;
    iodec_top uut (.*);
    iodec_chan_model far (.clk_sys_i, .sys_rst_i, .chan_req_i(chan_req_o), .dev_req_i(dev_req_o), .dly_i(m_dly),
        .cc_i(m_cc), .mute_i(m_mute), .chan_ack_o(chan_ack_i), .chan_cc_o(chan_cc_i), .dev_ack_o(dev_ack_i),
        .dev_cc_o(dev_cc_i));
    function [31:0] fc(input [3:0] p, input [2:0] r, input [15:0] k);
        fc = {6'h3f, r, p, 3'h7, k};
    endfunction
    function [31:0] lg(input [6:0] d, input t, input [15:0] k);
        lg = {6'h1f, d, 2'b01, t, k};
    endfunction
    task chk(input [31:0] g, input [31:0] e);
        begin
            comparisons = comparisons + 1;
            if (g !== e) begin
                err_total = err_total + 1;
                $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
            end
        end
    endtask
    task summarize;
        begin
            $display("comparisons=%0d err_total=%0d", comparisons, err_total);
            if (err_total == 0 && comparisons > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    task reg_rd(input [3:0] a);
        begin
            reg_addr_i <= a;
            reg_rd_i <= 1'b1;
            @(posedge clk_sys_i);
            reg_rd_i <= 1'b0;
            @(posedge clk_sys_i);
            rd = reg_rdata_o;
        end
    endtask
    task reg_wr(input [3:0] a, input [31:0] d);
        begin
            {reg_addr_i, reg_wdata_i, reg_wr_i} <= {a, d, 1'b1};
            @(posedge clk_sys_i);
            reg_wr_i <= 1'b0;
        end
    endtask
    // One instruction, then its code writes, requests and traps until done
    task issue(input [31:0] ins, input [2:0] kd, input [31:0] g, input dw, input cf, input pr, input bz);
        integer n;
        begin
            {sw, sy, su, sq, sd} = 5'h0;
            {sc, qop, qad, dt, dnum, dfn} = 'x;
            {instr_valid_i, instr_i, is_sense_dis_i, is_sense_en_i, is_legacy_i} <= {1'b1, ins, kd};
            {gpr_data_i, dw_mode_i, chan_classf_i, chan_present_i, chan_busy_i} <= {g, dw, cf, pr, bz};
            @(posedge clk_sys_i);
            lk = {gpr_sel_o, class_query_o};
            instr_valid_i <= 1'b0;
            n = 0;
            while (done_o !== 1'b1 && n < 400) begin
                @(posedge clk_sys_i);
                n = n + 1;
                if (cc_we_o === 1'b1) {sw, sc} = {1'b1, cc_o};
                if (chan_req_o === 1'b1) {sq, qop, qad} = {1'b1, chan_op_o, chan_addr_o};
                if (dev_req_o === 1'b1) {sd, dt, dnum, dfn} = {1'b1, dev_is_test_o, dev_num_o, dev_func_o};
                sy = sy | (trap_syschk_o === 1'b1);
                su = su | (trap_undef_o === 1'b1);
            end
            chk(n < 400, 1);
            @(posedge clk_sys_i);
        end
    endtask
    task t_reset;
        begin
            chk({done_o, cc_we_o, cc_o, irq_sense_o, chan_req_o, dev_req_o}, 0);
            for (s = 0; s < 4; s = s + 1) begin
                reg_rd(s[3:0]);
                chk(rd, 0);
            end
            reg_rd(4'hf);
            chk(rd, 0);
            reg_wr(4'h0, 32'h1);
            issue(lg(7'h22, 0, 16'h0100), 3'd1, 0, 0, 1, 1, 0);
            chk({sy, sd}, 2'b10);
            reg_rd(4'h0);
            chk(rd, 1);
            reg_wr(4'h0, 32'h0);
            $display("t_reset done");
        end
    endtask
    task t_wcs;
        begin
            issue(fc(4'hb, 0, 16'h0300), 0, 0, 1, 1, 1, 0);
            chk({sq, sc}, 5'h05);
            issue(fc(4'h9, 0, 16'h0300), 0, 0, 1, 1, 1, 0);
            chk({sq, qop, sc}, 9'h190);
            issue(fc(4'hb, 0, 16'h0300), 0, 0, 1, 1, 1, 0);
            chk({sq, qop}, 5'h1b);
            $display("t_wcs done");
        end
    endtask
    task t_subops;
        begin
            m_cc <= 4'h8;
            for (s = 0; s < 16; s = s + 1) if (s != 11) begin
                issue(fc(s[3:0], 3'd3, 16'h0120 + s[15:0]), 0, 32'h0001_0440, 1, 1, 1, 0);
                chk(lk, {3'd3, 7'h02});
                if (s < 2 || s == 10) begin
                    chk({sq, sc}, 5'h05);
                end else begin
                    chk({sq, qop, sw, sc}, {1'b1, s[3:0], 1'b1, 4'h8});
                    chk(qad, 32'h0001_0560 + s);
                end
            end
            issue(fc(4'h2, 0, 16'h0123), 0, 32'hdead_0000, 1, 1, 1, 0);
            chk(qad, 32'h0000_0123);
            $display("t_subops done");
        end
    endtask
    task t_codes;
        begin
            for (s = 0; s < 16; s = s + 1) begin
                {m_cc, m_dly} <= {s[3:0], s[7:0] * 8'd3};
                issue(fc(4'h3, 0, 16'h0200), 0, 0, 1, 1, 1, 0);
                chk({sw, sc}, (s < 6 || s == 8) ? 16 + s : 21);
            end
            issue(fc(4'h6, 0, 16'h0200), 0, 0, 1, 1, 1, 1);
            chk({sq, sc}, 5'h01);
            issue(fc(4'h6, 0, 16'h0200), 0, 0, 1, 1, 0, 0);
            chk({sq, sc}, 5'h02);
            issue(fc(4'h2, 0, 16'h0200), 0, 0, 1, 0, 1, 0);
            chk({sq, su}, 2'b01);
            {m_mute, m_dly} <= 9'h100;
            issue(fc(4'h2, 0, 16'h0200), 0, 0, 1, 1, 1, 0);
            chk(sc, 4'h2);
            m_mute <= 1'b0;
            $display("t_codes done");
        end
    endtask
    task t_legacy;
        begin
            m_cc <= 4'h6;
            issue(lg(7'h7a, 0, 16'h8000), 3'd1, 0, 0, 0, 1, 0);
            chk({sd, dt, dnum, dfn, sw}, {1'b1, 1'b0, 7'h7a, 16'h8000, 1'b0});
            chk(lk[6:0], 7'h7a);
            reg_rd(4'h3);
            chk(rd, 32'h0000_8000);
            issue(lg(7'h10, 1, 16'h1234), 3'd1, 0, 0, 0, 1, 0);
            chk({sd, dt, dfn, sw, sc}, {1'b1, 1'b1, 16'h1230, 1'b1, 4'h6});
            issue(lg(7'h11, 0, 16'h8000), 3'd1, 0, 0, 1, 1, 0);
            chk({sw, sd, sy}, 0);
            for (s = 0; s < 3; s = s + 1) begin
                issue(lg(7'h11, 1, 16'h8000 >> s), 3'd1, 0, 0, 1, 1, 0);
                chk({sw, sc, sd}, {1'b1, (s == 2) ? 4'h4 : 4'h2, 1'b0});
            end
            for (s = 0; s < 2; s = s + 1) begin
                issue(lg(7'h11, s[0], 16'h2000), 3'd1, 0, 1, 1, 1, 0);
                chk({sy, sd}, 2'b10);
            end
            $display("t_legacy done");
        end
    endtask
    task t_sense;
        begin
            issue(0, 3'd2, 0, 1, 0, 0, 0);
            chk({sw, irq_sense_o}, 2'b01);
            reg_rd(4'h1);
            chk(rd[4], 1);
            issue(0, 3'd4, 0, 1, 0, 0, 0);
            chk({sw, irq_sense_o}, 2'b00);
            $display("t_sense done");
        end
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        err_total = err_total + 1;
        summarize;
    end
    initial begin
        repeat (20) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_sys_i);
        t_reset;
        t_wcs;
        t_subops;
        t_codes;
        t_legacy;
        t_sense;
        summarize;
    end
endmodule

// file: tb/iodec_chan_model.sv
`timescale 1ns/1ps
// Far-side channel and device controller: answers each request after dly_i idle cycles, except channel requests taken while mute_i is set
module iodec_chan_model (
    // Clock and reset
    input  wire       clk_sys_i,
    input  wire       sys_rst_i,
    // Requests and answer settings
    input  wire       chan_req_i,
    input  wire       dev_req_i,
    input  wire [7:0] dly_i,
    input  wire [3:0] cc_i,
    input  wire       mute_i,
    // Answers
    output reg        chan_ack_o,
    output reg  [3:0] chan_cc_o,
    output reg        dev_ack_o,
    output reg  [3:0] dev_cc_o
);
    reg [7:0] cw;
    reg [7:0] dw;
    reg       ca;
    reg       da;
    always @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            {ca, da, chan_ack_o, dev_ack_o} <= 4'h0;
            {cw, dw, chan_cc_o, dev_cc_o} <= 24'h0;
        end else begin
            chan_ack_o <= 1'b0;
            dev_ack_o <= 1'b0;
            // Code lines wander between answers so a stale code never looks valid
            chan_cc_o <= ~chan_cc_o;
            dev_cc_o <= ~dev_cc_o;
            // Subaddress and chain flags are not modelled, only the answer
            if (chan_req_i) begin
                ca <= !mute_i;
                cw <= dly_i;
            end else if (ca && cw != 8'h00) begin
                cw <= cw - 8'h01;
            end else if (ca) begin
                ca <= 1'b0;
                chan_ack_o <= 1'b1;
                chan_cc_o <= cc_i;
            end
            if (dev_req_i) begin
                da <= 1'b1;
                dw <= dly_i;
            end else if (da && dw != 8'h00) begin
                dw <= dw - 8'h01;
            end else if (da) begin
                da <= 1'b0;
                dev_ack_o <= 1'b1;
                dev_cc_o <= cc_i;
            end
        end
    end
endmodule

// file: tb/iodec_top_asserts.sv
`timescale 1ns/1ps
module iodec_top_asserts (
    input wire        clk_sys_i,
    input wire        sys_rst_i,
    input wire        instr_valid_i,
    input wire [31:0] instr_i,
    input wire        is_legacy_i,
    input wire        is_sense_en_i,
    input wire        is_sense_dis_i,
    input wire [31:0] gpr_data_i,
    input wire        dw_mode_i,
    input wire        chan_classf_i,
    input wire        chan_present_i,
    input wire        chan_busy_i,
    input wire        chan_ack_i,
    input wire        done_o,
    input wire [3:0]  cc_o,
    input wire        cc_we_o,
    input wire        trap_syschk_o,
    input wire        trap_undef_o,
    input wire        irq_sense_o,
    input wire        chan_req_o,
    input wire [3:0]  chan_op_o,
    input wire [31:0] chan_addr_o,
    input wire        dev_req_o,
    input wire [6:0]  dev_num_o,
    input wire [15:0] dev_func_o
);
    reg         busy_q;
    reg  [1:0]  kind_q;
    wire        go   = instr_valid_i && !busy_q;
    wire        cls  = go && instr_i[31:26] == 6'h3f && instr_i[18:16] == 3'h7 && !is_legacy_i
                       && !is_sense_en_i && !is_sense_dis_i;
    wire        ok   = cls && chan_present_i && chan_classf_i;
    wire [3:0]  sop  = instr_i[22:19];
    wire        una  = sop < 4'h2 || sop == 4'ha;
    wire        fwd  = ok && !una && sop != 4'hb;
    wire        lga  = go && is_legacy_i;
    wire [31:0] lcsa = {16'h0000, instr_i[15:0]} + (instr_i[25:23] != 3'h0 ? gpr_data_i : 32'h0);
    // Issues while busy are dropped, so only taken ones are tracked
    always @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            busy_q <= 1'b0;
            kind_q <= 2'd0;
        end else if (go) begin
            busy_q <= 1'b1;
            kind_q <= cls ? 2'd1 : (lga && !instr_i[16]) ? 2'd2 : 2'd0;
        end else if (done_o) begin
            busy_q <= 1'b0;
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    unassigned_sop_a: assert property (ok && una |=> cc_we_o && cc_o == 4'h5 && !chan_req_o ##1 done_o)
        else $error("unassigned sub-op not refused");
    undef_trap_a: assert property (cls && chan_present_i && !chan_classf_i |=> trap_undef_o && !chan_req_o)
        else $error("no undefined trap");
    absent_chan_a: assert property (cls && !chan_present_i |=> cc_we_o && cc_o == 4'h2)
        else $error("absent channel code wrong");
    busy_chan_a: assert property (fwd && chan_busy_i |=> cc_we_o && cc_o == 4'h1 && !chan_req_o)
        else $error("busy channel code wrong");
    forward_op_a: assert property (fwd && !chan_busy_i |=> chan_req_o && chan_op_o == $past(sop)
        && chan_addr_o == $past(lcsa)) else $error("forwarded op or address wrong");
    ack_result_a: assert property (busy_q && chan_ack_i |=> cc_we_o ##1 done_o)
        else $error("channel answer not reported");
    legal_cc_a: assert property (cc_we_o && kind_q == 2'd1 |-> cc_o inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8})
        else $error("unassigned code produced");
    no_cmd_cc_a: assert property (kind_q == 2'd2 |-> !cc_we_o)
        else $error("command wrote code");
    legacy_fields_a: assert property (lga && chan_present_i && !chan_classf_i |=> dev_req_o
        && dev_num_o == $past(instr_i[25:19]) && dev_func_o == ($past(instr_i[16]) ?
        {$past(instr_i[15:4]), 4'h0} : $past(instr_i[15:0]))) else $error("device fields wrong");
    dw_syschk_a: assert property (lga && chan_classf_i && dw_mode_i |=> trap_syschk_o && !dev_req_o)
        else $error("no system check");
    sense_on_a: assert property (go && is_sense_en_i |=> !cc_we_o ##1 irq_sense_o)
        else $error("sense enable wrong");
    sense_off_a: assert property (go && is_sense_dis_i |=> !cc_we_o ##1 !irq_sense_o)
        else $error("sense disable wrong");
endmodule
bind iodec_top iodec_top_asserts u_chk (.*);
